/* File: hw/etrda_pkg.sv */
// shared constants of the e1/t1 receive decode and alarm block
package etrda_pkg;
    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_CTRL0 = 4'h0;
    localparam logic [3:0] REG_CTRL1 = 4'h1;
    localparam logic [3:0] REG_GLOBAL = 4'h2;
    localparam logic [3:0] REG_EQ_STATUS = 4'h3;
    localparam logic [3:0] REG_LINE_STATUS_0 = 4'h4;
    localparam logic [3:0] REG_INT_STATUS_0 = 4'h5;
    localparam logic [3:0] REG_INT_MASK_0 = 4'h6;
    localparam logic [3:0] REG_CV_LOW = 4'h7;
    localparam logic [3:0] REG_CV_HIGH = 4'h8;
    // field positions
    localparam int C0_OPTICAL = 0;
    localparam int C0_LONG_HAUL = 1;
    localparam int C0_EXT_VIOL = 2;
    localparam int C0_T1 = 3;
    localparam int C0_VISIBLE = 4;
    localparam int C0_ZERO_SUBST = 5;
    localparam int C1_SLICER_LSB = 0;
    localparam int C1_ROUTE_LSB = 2;
    localparam int G_FLEX = 0;
    localparam int G_T1 = 1;
    localparam int ST_DENSITY = 0;
    localparam int ST_BLUE = 1;
    // reset values
    localparam logic [7:0] CTRL0_RST = 8'h20;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    // slicer threshold codes: 45, 50, 55, 67 percent of peak
    localparam logic [1:0] SLICER_45 = 2'h0;
    localparam logic [1:0] SLICER_50 = 2'h1;
    localparam logic [1:0] SLICER_55 = 2'h2;
    localparam logic [1:0] SLICER_67 = 2'h3;
    localparam logic [1:0] ROUTE_CDR = 2'h0;
    // equalizer status
    localparam logic [1:0] EQ_VALID_CODE = 2'h1;
    localparam logic [1:0] EQ_INVALID_CODE = 2'h0;
    localparam logic [4:0] EQ_MAX_STEP = 5'h18;
    // clock recovery
    localparam longint MCLK_HZ = 25000000;
    localparam longint E1_HZ = 2048000;
    localparam longint T1_HZ = 1544000;
    localparam int NCO_W = 24;
    localparam logic [23:0] NCO_INC_E1 = 24'((E1_HZ << NCO_W) / MCLK_HZ);
    localparam logic [23:0] NCO_INC_T1 = 24'((T1_HZ << NCO_W) / MCLK_HZ);
    localparam logic [23:0] PHASE_QTR = 24'h400000;
    // line decoder window
    localparam int DECODE_DEPTH = 8;
    localparam logic [7:0] HDB3_000V_CLR = 8'h01;
    localparam logic [7:0] HDB3_B00V_CLR = 8'h09;
    localparam logic [7:0] B8ZS_CLR = 8'h1B;
    localparam logic [7:0] B8ZS_ZERO = 8'hE4;
    localparam logic [7:0] B8ZS_SAME = 8'h11;
    localparam logic [7:0] B8ZS_OPP = 8'h0A;
    // pulse density
    localparam int AGE_W = 8;
    localparam logic [7:0] AGE_MAX = 8'hFF;
    localparam int DENS_N_MAX = 23;
    localparam int DENS_SLOT = 8;
    localparam logic [7:0] ZERO_RUN_LIMIT = 8'h0F;
    // blue alarm
    localparam int AIS_WIN_W = 17;
    localparam int E1_AIS_BITS = 512;
    localparam logic [2:0] E1_AIS_ZEROS = 3'h3;
    localparam logic [2:0] T1_AIS_ZEROS = 3'h6;
    localparam longint T1_AIS_US = 3000;
    localparam int T1_AIS_CYCLES = int'((T1_AIS_US * MCLK_HZ) / 1000000);
    // violation counter
    localparam int CV_W = 16;
    localparam logic [15:0] CV_MAX = 16'hFFFF;
endpackage : etrda_pkg

/* File: hw/etrda_line_decoder.sv */
// line code decoder: hdb3, b8zs and ami with code violation flagging
`timescale 1ns/1ps
module etrda_line_decoder (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // symbols, one per bit slot
    input wire logic i_sym_valid,
    input wire logic i_sym_pos,
    input wire logic i_sym_neg,
    // mode
    input wire logic i_t1_mode,
    input wire logic i_zero_subst,
    input wire logic i_ext_viol,
    // decoded stream
    output logic o_bit_valid,
    output logic o_bit,
    output logic o_code_violation
);
    localparam int DEPTH = etrda_pkg::DECODE_DEPTH;
    logic [DEPTH-1:0] win_pos;
    logic [DEPTH-1:0] win_neg;
    logic [DEPTH-1:0] raw_pos;
    logic [DEPTH-1:0] raw_neg;
    logic [DEPTH-1:0] clr;
    logic [1:0] zero_run;
    logic in_neg;
    logic v_neg;
    logic v_seen;
    logic out_neg;
    logic hdb3;
    logic pulse_in;
    logic hdb3_sub;
    logic prev_neg;
    logic b8zs_hit;
    logic pulse_out;
    logic cv_in;
    logic cv_out;

    assign hdb3 = ~i_t1_mode & i_zero_subst;
    assign pulse_in = i_sym_pos | i_sym_neg;
    assign raw_pos = {win_pos[DEPTH-2:0], i_sym_pos};
    assign raw_neg = {win_neg[DEPTH-2:0], i_sym_neg};
    // a violation after two or more zeros is a substitution
    assign hdb3_sub = hdb3 & pulse_in & (i_sym_neg == in_neg) & (zero_run >= 2'h2);
    assign prev_neg = (win_pos[DEPTH-1] | win_neg[DEPTH-1]) ? win_neg[DEPTH-1] : out_neg;
    assign b8zs_hit = i_t1_mode & i_zero_subst & (((raw_pos | raw_neg) & etrda_pkg::B8ZS_ZERO) == '0)
        & ((prev_neg ? raw_neg : raw_pos) & etrda_pkg::B8ZS_CLR) == etrda_pkg::B8ZS_SAME
        & ((prev_neg ? raw_pos : raw_neg) & etrda_pkg::B8ZS_CLR) == etrda_pkg::B8ZS_OPP;
    assign clr = hdb3_sub ? ((zero_run == 2'h2) ? etrda_pkg::HDB3_B00V_CLR
        : etrda_pkg::HDB3_000V_CLR) : (b8zs_hit ? etrda_pkg::B8ZS_CLR : '0);
    // hdb3: plain or repeated-polarity violations, optional excess zeros
    assign cv_in = hdb3 & ((pulse_in & (i_sym_neg == in_neg)
        & (~hdb3_sub | (v_seen & (i_sym_neg == v_neg))))
        | (i_ext_viol & ~pulse_in & (zero_run == 2'h3)));
    // ami and b8zs: substitutions are gone by now, any repeat is an error
    assign pulse_out = win_pos[DEPTH-1] | win_neg[DEPTH-1];
    assign cv_out = ~hdb3 & pulse_out & (win_neg[DEPTH-1] == out_neg);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            win_pos <= '0;
            win_neg <= '0;
        end else if (i_sym_valid) begin
            win_pos <= raw_pos & ~clr;
            win_neg <= raw_neg & ~clr;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            zero_run <= '0;
            in_neg <= 1'b1;
            out_neg <= 1'b1;
        end else if (i_sym_valid) begin
            zero_run <= pulse_in ? 2'h0 : ((zero_run == 2'h3) ? zero_run : zero_run + 2'h1);
            in_neg <= pulse_in ? i_sym_neg : in_neg;
            out_neg <= pulse_out ? win_neg[DEPTH-1] : out_neg;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            v_seen <= 1'b0;
            v_neg <= 1'b0;
        end else if (i_sym_valid && hdb3_sub) begin
            v_seen <= 1'b1;
            v_neg <= i_sym_neg;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_bit_valid <= 1'b0;
            o_bit <= 1'b0;
            o_code_violation <= 1'b0;
        end else begin
            o_bit_valid <= i_sym_valid;
            o_bit <= i_sym_valid & pulse_out;
            o_code_violation <= i_sym_valid & (cv_in | cv_out);
        end
    end
endmodule : etrda_line_decoder

/* File: hw/etrda_rx.sv */
// receive path: input select, clock recovery, decode, density and blue alarm
`timescale 1ns/1ps
module etrda_rx #(
    parameter int T1_AIS_CYCLES = etrda_pkg::T1_AIS_CYCLES
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // sliced line and optical inputs
    input wire logic i_line_in_pos,
    input wire logic i_line_in_neg,
    input wire logic i_optical_data_in,
    // equalizer front end
    input wire logic [4:0] i_eq_atten,
    input wire logic i_eq_settled,
    output logic o_long_haul_enable,
    output logic [1:0] o_slicer_threshold_sel,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    // receive outputs
    output logic o_raw_data_out_pos,
    output logic o_raw_data_out_neg,
    output logic o_rx_clk,
    output logic o_rx_data,
    output logic o_rx_data_valid,
    output logic o_density_violation_status,
    output logic o_blue_alarm_status,
    output logic o_irq
);
    localparam int NW = etrda_pkg::NCO_W;
    localparam int AW = etrda_pkg::AGE_W;
    localparam int WW = etrda_pkg::AIS_WIN_W;
    localparam logic [WW-1:0] E1_WIN_END = WW'(etrda_pkg::E1_AIS_BITS - 1);
    localparam logic [WW-1:0] T1_WIN_END = WW'(T1_AIS_CYCLES - 1);

    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] glob;
    logic [1:0] int_mask;
    logic [1:0] int_status;
    logic [1:0] status_q;
    logic [1:0] events;
    logic [1:0] keep_events;
    logic [15:0] cv_count;
    logic [7:0] cv_high_snap;
    logic [7:0] next_rd_data;
    logic optical;
    logic t1_mode;
    logic route_cdr;
    logic wr_ctrl;
    logic int_rd;
    logic cv_low_rd;
    logic visible;

    assign optical = ctrl0[etrda_pkg::C0_OPTICAL];
    assign visible = ctrl0[etrda_pkg::C0_VISIBLE];
    // per-channel rate only counts with the flexible clock on
    assign t1_mode = glob[etrda_pkg::G_FLEX] ? ctrl0[etrda_pkg::C0_T1]
        : glob[etrda_pkg::G_T1];
    assign route_cdr = ctrl1[etrda_pkg::C1_ROUTE_LSB +: 2] == etrda_pkg::ROUTE_CDR;
    assign o_long_haul_enable = ctrl0[etrda_pkg::C0_LONG_HAUL];
    assign o_slicer_threshold_sel = ctrl1[etrda_pkg::C1_SLICER_LSB +: 2];
    assign int_rd = i_rd & (i_addr == etrda_pkg::REG_INT_STATUS_0);
    assign cv_low_rd = i_rd & (i_addr == etrda_pkg::REG_CV_LOW);
    assign wr_ctrl = i_wr;

    // control registers
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ctrl0 <= etrda_pkg::CTRL0_RST;
            ctrl1 <= etrda_pkg::CTRL1_RST;
            glob <= etrda_pkg::GLOBAL_RST;
            int_mask <= etrda_pkg::MASK_RST;
        end else if (wr_ctrl) begin
            if (i_addr == etrda_pkg::REG_CTRL0) begin
                ctrl0 <= i_wr_data;
            end
            if (i_addr == etrda_pkg::REG_CTRL1) begin
                ctrl1 <= i_wr_data;
            end
            if (i_addr == etrda_pkg::REG_GLOBAL) begin
                glob <= i_wr_data;
            end
            if (i_addr == etrda_pkg::REG_INT_MASK_0) begin
                int_mask <= i_wr_data[1:0];
            end
        end
    end

    // clock recovery: phase accumulator, realigned on line edges
    logic [NW-1:0] phase;
    logic [NW:0] phase_sum;
    logic line_q;
    logic opt_q;
    logic resync;
    logic half_tick;
    logic full_tick;
    logic cmi_first;
    logic sym_valid;
    logic sym_pos;
    logic sym_neg;

    assign phase_sum = {1'b0, phase} + {1'b0, t1_mode ? etrda_pkg::NCO_INC_T1
        : etrda_pkg::NCO_INC_E1};
    // cmi only falls on a bit boundary, ternary pulses rise at bit start
    assign resync = route_cdr & (optical ? (opt_q & ~i_optical_data_in)
        : ((i_line_in_pos | i_line_in_neg) & ~line_q));
    assign half_tick = ~resync & ~phase[NW-1] & phase_sum[NW-1] & ~phase_sum[NW];
    assign full_tick = ~resync & phase_sum[NW];

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            phase <= '0;
            line_q <= 1'b0;
            opt_q <= 1'b0;
            o_rx_clk <= 1'b0;
        end else begin
            phase <= resync ? etrda_pkg::PHASE_QTR : phase_sum[NW-1:0];
            line_q <= i_line_in_pos | i_line_in_neg;
            opt_q <= i_optical_data_in;
            o_rx_clk <= ~phase[NW-1];
        end
    end

    // symbol capture; cmi pairs map 11 and 00 to marks, 01 and 10 to space
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cmi_first <= 1'b0;
            sym_valid <= 1'b0;
            sym_pos <= 1'b0;
            sym_neg <= 1'b0;
        end else begin
            cmi_first <= half_tick ? i_optical_data_in : cmi_first;
            sym_valid <= route_cdr & (optical ? full_tick : half_tick);
            if (optical) begin
                sym_pos <= cmi_first & i_optical_data_in;
                sym_neg <= ~cmi_first & ~i_optical_data_in;
            end else begin
                sym_pos <= i_line_in_pos;
                sym_neg <= i_line_in_neg;
            end
        end
    end

    // bypass of recovery straight to the raw rails
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_raw_data_out_pos <= 1'b0;
            o_raw_data_out_neg <= 1'b0;
        end else begin
            o_raw_data_out_pos <= ~route_cdr & i_line_in_pos;
            o_raw_data_out_neg <= ~route_cdr & i_line_in_neg;
        end
    end

    logic dec_cv;

    etrda_line_decoder u_decoder (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_sym_valid(sym_valid),
        .i_sym_pos(sym_pos),
        .i_sym_neg(sym_neg),
        .i_t1_mode(t1_mode),
        .i_zero_subst(ctrl0[etrda_pkg::C0_ZERO_SUBST]),
        .i_ext_viol(ctrl0[etrda_pkg::C0_EXT_VIOL]),
        .o_bit_valid(o_rx_data_valid),
        .o_bit(o_rx_data),
        .o_code_violation(dec_cv)
    );

    // pulse density: age of the n-th most recent one, in bit slots
    logic [AW-1:0] age [etrda_pkg::DENS_N_MAX];
    logic [etrda_pkg::DENS_N_MAX-1:0] dens_hit;
    logic zero_run_hit;

    assign zero_run_hit = age[0] > etrda_pkg::ZERO_RUN_LIMIT;

    for (genvar k = 0; k < etrda_pkg::DENS_N_MAX; k++) begin : g_age
        logic [AW-1:0] older;
        logic [AW-1:0] prev_age;
        if (k == 0) begin : g_first
            assign prev_age = '0;
        end else begin : g_rest
            assign prev_age = (age[k-1] == etrda_pkg::AGE_MAX) ? age[k-1] : age[k-1] + 8'h01;
        end
        assign older = (age[k] == etrda_pkg::AGE_MAX) ? age[k] : age[k] + 8'h01;
        // fewer than k+1 ones within 8*(k+2) slots
        assign dens_hit[k] = age[k] >= AW'(etrda_pkg::DENS_SLOT * (k + 2));
        always_ff @(posedge i_mclk or posedge i_reset) begin
            if (i_reset) begin
                age[k] <= etrda_pkg::AGE_MAX;
            end else if (o_rx_data_valid) begin
                age[k] <= o_rx_data ? prev_age : older;
            end
        end
    end

    // level follows the window, so it drops once ones arrive in time
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_density_violation_status <= 1'b0;
        end else begin
            o_density_violation_status <= zero_run_hit | (|dens_hit);
        end
    end

    // blue alarm: e1 counts bit periods, t1 counts master clocks
    logic [WW-1:0] ais_win;
    logic [2:0] ais_zeros;
    logic [2:0] zeros_now;
    logic ais_end;
    logic quiet;
    logic quiet_prev;

    assign zeros_now = (o_rx_data_valid && !o_rx_data && ais_zeros != 3'h7)
        ? ais_zeros + 3'h1 : ais_zeros;
    // a mode switch can leave the window past the new end, so compare with >=
    assign ais_end = t1_mode ? (ais_win >= T1_WIN_END)
        : (o_rx_data_valid && ais_win >= E1_WIN_END);
    assign quiet = zeros_now < (t1_mode ? etrda_pkg::T1_AIS_ZEROS : etrda_pkg::E1_AIS_ZEROS);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ais_win <= '0;
            ais_zeros <= '0;
            quiet_prev <= 1'b0;
            o_blue_alarm_status <= 1'b0;
        end else if (ais_end) begin
            ais_win <= '0;
            ais_zeros <= '0;
            quiet_prev <= quiet;
            o_blue_alarm_status <= t1_mode ? quiet : (quiet & quiet_prev);
        end else begin
            ais_win <= (t1_mode || o_rx_data_valid) ? ais_win + WW'(1) : ais_win;
            ais_zeros <= zeros_now;
        end
    end

    // event register: rising status edges, cleared by reading, set wins
    assign events = {o_blue_alarm_status, o_density_violation_status} & ~status_q;
    assign keep_events = events & (~int_mask | {2{visible}});

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            status_q <= '0;
            int_status <= '0;
        end else begin
            status_q <= {o_blue_alarm_status, o_density_violation_status};
            int_status <= (int_rd ? 2'h0 : int_status) | keep_events;
        end
    end

    assign o_irq = |(int_status & ~int_mask);

    // violation counter; reading the low byte snapshots high and restarts
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cv_count <= '0;
            cv_high_snap <= '0;
        end else if (cv_low_rd) begin
            cv_count <= {15'h0000, dec_cv};
            cv_high_snap <= cv_count[15:8];
        end else if (dec_cv && cv_count != etrda_pkg::CV_MAX) begin
            cv_count <= cv_count + 16'h0001;
        end
    end

    // read mux, data valid only in the cycle after the strobe
    always_comb begin
        next_rd_data = 8'h00;
        unique case (i_addr)
            etrda_pkg::REG_CTRL0: next_rd_data = ctrl0;
            etrda_pkg::REG_CTRL1: next_rd_data = ctrl1;
            etrda_pkg::REG_GLOBAL: next_rd_data = glob;
            etrda_pkg::REG_EQ_STATUS: next_rd_data = {i_eq_settled ? etrda_pkg::EQ_VALID_CODE
                : etrda_pkg::EQ_INVALID_CODE, 1'b0, (i_eq_atten > etrda_pkg::EQ_MAX_STEP)
                ? etrda_pkg::EQ_MAX_STEP : i_eq_atten};
            etrda_pkg::REG_LINE_STATUS_0: next_rd_data = {6'h00, status_q};
            etrda_pkg::REG_INT_STATUS_0: next_rd_data = {6'h00, int_status};
            etrda_pkg::REG_INT_MASK_0: next_rd_data = {6'h00, int_mask};
            etrda_pkg::REG_CV_LOW: next_rd_data = cv_count[7:0];
            etrda_pkg::REG_CV_HIGH: next_rd_data = cv_high_snap;
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= i_rd ? next_rd_data : 8'h00;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_line_select: assert property (half_tick && route_cdr && !optical
        |=> sym_valid && sym_pos == $past(i_line_in_pos)) else $error("line sample lost");
    a_bypass_raw: assert property (!route_cdr
        |=> o_raw_data_out_pos == $past(i_line_in_pos) && !sym_valid)
        else $error("bypass rail wrong");
    a_eq_valid: assert property (i_rd && i_addr == etrda_pkg::REG_EQ_STATUS
        |=> (o_rd_data[7:6] == etrda_pkg::EQ_VALID_CODE) == $past(i_eq_settled))
        else $error("equalizer valid code wrong");
    a_cv_count: assert property (dec_cv && !cv_low_rd && cv_count != etrda_pkg::CV_MAX
        |=> cv_count == $past(cv_count) + 16'h0001) else $error("violation not counted");
    a_cv_saturate: assert property (cv_count == etrda_pkg::CV_MAX && !cv_low_rd
        |=> cv_count == etrda_pkg::CV_MAX) else $error("violation counter wrapped");
    a_zero_run: assert property (zero_run_hit && !i_reset
        |=> o_density_violation_status ##1 (int_status[etrda_pkg::ST_DENSITY]
        || $past(status_q[etrda_pkg::ST_DENSITY])
        || ($past(int_mask[etrda_pkg::ST_DENSITY]) && !$past(visible))))
        else $error("zero run missed");
    a_read_clears: assert property (int_rd && keep_events == 2'h0
        |=> int_status == 2'h0 && !o_irq) else $error("event read did not clear");
    a_masked_hidden: assert property (!visible && int_mask == 2'h3 && int_status == 2'h0
        |=> int_status == 2'h0 && !o_irq) else $error("masked event visible");
    a_flex_gate: assert property (!glob[etrda_pkg::G_FLEX]
        |-> t1_mode == glob[etrda_pkg::G_T1]) else $error("per-channel mode leaked");
    a_free_run: assert property (!resync && phase_sum[NW]
        |=> phase == $past(phase_sum[NW-1:0])) else $error("recovered clock stalled");

    c_density: cover property ($rose(o_density_violation_status));
    c_blue: cover property ($rose(o_blue_alarm_status));
    c_irq_read: cover property (o_irq ##1 int_rd ##1 !o_irq);
    c_cv_full: cover property (cv_count == etrda_pkg::CV_MAX);
endmodule : etrda_rx

/* File: verif/etrda_line_tx.sv */
// remote line transmitter model: ami marks on the ternary rails
`timescale 1ns/1ps
module etrda_line_tx #(
    parameter int BIT_CYC = 12
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // traffic control
    input wire logic i_ones,
    input wire logic i_viol,
    // line rails
    output logic o_pos,
    output logic o_neg
);
    int cnt;
    logic pol;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cnt <= 0;
            pol <= 1'b0;
            o_pos <= 1'b0;
            o_neg <= 1'b0;
        end else begin
            cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
            if (cnt == 0 && i_ones) begin
                // a violation repeats the last mark polarity
                o_pos <= i_viol ? pol : ~pol;
                o_neg <= i_viol ? ~pol : pol;
                pol <= i_viol ? pol : ~pol;
            end else if (cnt == BIT_CYC / 2) begin
                o_pos <= 1'b0;
                o_neg <= 1'b0;
            end
        end
    end
endmodule : etrda_line_tx

/* File: verif/tb_e1_t1_receive_decode_alarms.sv */
// bench for the e1/t1 receive decode and alarm block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_e1_t1_receive_decode_alarms;
    logic i_mclk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_eq_settled = 0, ones = 0, viol = 0;
    logic [3:0] i_addr = 0;
    logic [7:0] i_wr_data = 0, rv, rdd;
    logic [4:0] i_eq_atten = 0, ea;
    logic [1:0] slt, p;
    logic lp, ln, rdp, rdn, lh, dens, blue, irq, rclk;
    int fail_count = 0, checks = 0, mdl[16], rclk_n = 0, n0;
    always #20 i_mclk = ~i_mclk;
    // recovered clock edges, for the free-run rate with no pulses
    always @(posedge rclk) rclk_n++;
    etrda_line_tx tx (.i_mclk(i_mclk), .i_reset(i_reset), .i_ones(ones), .i_viol(viol),
        .o_pos(lp), .o_neg(ln));
    etrda_rx #(.T1_AIS_CYCLES(200)) dut (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_line_in_pos(lp), .i_line_in_neg(ln), .i_optical_data_in(1'b0),
        .i_eq_atten(i_eq_atten), .i_eq_settled(i_eq_settled), .o_long_haul_enable(lh),
        .o_slicer_threshold_sel(slt), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
        .i_rd(i_rd), .o_rd_data(rdd), .o_raw_data_out_pos(rdp), .o_raw_data_out_neg(rdn),
        .o_rx_clk(rclk), .o_rx_data(), .o_rx_data_valid(), .o_density_violation_status(dens),
        .o_blue_alarm_status(blue), .o_irq(irq));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        mdl[a] = d;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = rdd;
    endtask : rd
    task automatic bits(input int n);
        repeat (n * 12) @(posedge i_mclk);
        #1;
    endtask : bits
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge i_mclk);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hF906));
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        mdl[0] = 8'h20;
        foreach (mdl[a]) if (a < 7 && a != 3 && a != 4 && a != 5 || a > 9) begin
            rd(4'(a), rv);
            `CHK("reg", 8'(mdl[a]), rv)
        end
        `CHK("long_haul", 1'b0, lh)
        for (int i = 0; i < 4; i++) begin
            wr(4'h1, 8'(i));
            `CHK("slicer", 2'(i), slt)
        end
        wr(4'h0, 8'h22);
        `CHK("long_haul", 1'b1, lh)
        wr(4'h0, 8'h20);
        repeat (8) begin
            i_eq_atten <= 5'($urandom);
            i_eq_settled <= 1'($urandom);
            rd(4'h3, rv);
            // 25 steps: anything beyond step 24 reads as 24
            ea = (i_eq_atten > 5'h18) ? 5'h18 : i_eq_atten;
            `CHK("eq_status", {1'b0, i_eq_settled, 1'b0, ea}, rv)
        end
        $display("config test done");
        wr(4'h1, 8'h04);
        ones <= 1'b1;
        repeat (60) begin
            p = {lp, ln};
            @(posedge i_mclk);
            #1 `CHK("raw", p, {rdp, rdn})
        end
        wr(4'h1, 8'h00);
        ones <= 1'b0;
        n0 = rclk_n;
        bits(30);
        `CHK("rx_clk_e1", 1'b1, 1'((rclk_n - n0) inside {[28:31]}))
        `CHK("density", 1'b1, dens)
        `CHK("irq", 1'b1, irq)
        rd(4'h5, rv);
        `CHK("events", 8'h01, rv)
        `CHK("irq", 1'b0, irq)
        rd(4'h5, rv);
        `CHK("events", 8'h00, rv)
        $display("density test done");
        ones <= 1'b1;
        // one partial and two full 512-bit periods, plus decoder latency
        bits(1600);
        `CHK("blue", 1'b1, blue)
        `CHK("density", 1'b0, dens)
        `CHK("irq", 1'b1, irq)
        rd(4'h5, rv);
        `CHK("events", 8'h02, rv)
        wr(4'h6, 8'h01);
        ones <= 1'b0;
        bits(40);
        `CHK("density", 1'b1, dens)
        `CHK("irq", 1'b0, irq)
        rd(4'h5, rv);
        `CHK("events", 8'h00, rv)
        $display("alarm test done");
        ones <= 1'b1;
        // first pass hdb3, second pass ami
        for (int m = 0; m < 2; m++) begin
            wr(4'h0, (m == 0) ? 8'h20 : 8'h00);
            bits(30);
            rd(4'h7, rv);
            viol <= 1'b1;
            repeat (12) @(posedge i_mclk);
            viol <= 1'b0;
            bits(30);
            rd(4'h7, rv);
            `CHK("cv_low", 8'h01, rv)
            rd(4'h8, rv);
            `CHK("cv_high", 8'h00, rv)
        end
        $display("violation test done");
        wr(4'h2, 8'h02);
        ones <= 1'b0;
        n0 = rclk_n;
        bits(50);
        `CHK("rx_clk_t1", 1'b1, 1'((rclk_n - n0) inside {[35:38]}))
        `CHK("blue_t1", 1'b0, blue)
        ones <= 1'b1;
        bits(60);
        `CHK("blue_t1", 1'b1, blue)
        $display("t1 alarm test done");
        end_sim();
    end
endmodule : tb_e1_t1_receive_decode_alarms
